// *** shared/dma_pkg.sv ***
// constants, field layout and enumerations of the channel engine
package dma_pkg;
  localparam int NUM_CH = 32;
  localparam int CHW    = 5;
  localparam int CNTW   = 11;
  // register offsets
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_BASE   = 8'h04;
  localparam logic [7:0] OFF_ENSET  = 8'h08;
  localparam logic [7:0] OFF_ENCLR  = 8'h0C;
  localparam logic [7:0] OFF_SWREQ  = 8'h10;
  localparam logic [7:0] OFF_PRSET  = 8'h14;
  localparam logic [7:0] OFF_PRCLR  = 8'h18;
  localparam logic [7:0] OFF_ERR    = 8'h1C;
  localparam logic [7:0] OFF_STAT   = 8'h20;
  localparam logic [7:0] OFF_SWDONE = 8'h24;
  localparam logic [7:0] OFF_ALT    = 8'h28;
  // control table: base aligned to 1024 bytes, 16 bytes per structure
  localparam int         BASE_LSB = 10;
  localparam logic [3:0] W_SRC    = 4'h0;
  localparam logic [3:0] W_DST    = 4'h4;
  localparam logic [3:0] W_CTL    = 4'h8;
  // control word fields
  localparam int F_MODE = 0;
  localparam int F_CNT  = 4;
  localparam int F_ARB  = 15;
  localparam int F_SIZE = 19;
  localparam int F_SINC = 21;
  localparam int F_DINC = 23;
  localparam logic [3:0]      ARB_MAX       = 4'hA;
  localparam logic [CNTW-1:0] SG_TASK_WORDS = 11'h004;
  localparam logic [1:0]      SIZE_WORD     = 2'h2;
  localparam logic [CHW-1:0]  SW_CHANNEL    = 5'h1F;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [21:0] RST_BASE = 22'h00_0000;
  localparam logic [CNTW-1:0] RST_CNT = 11'h000;

  typedef enum logic [2:0] {
    MODE_STOP      = 3'h0,
    MODE_BASIC     = 3'h1,
    MODE_AUTO      = 3'h2,
    MODE_PINGPONG  = 3'h3,
    MODE_MEMSG     = 3'h4,
    MODE_MEMSG_ALT = 3'h5,
    MODE_PERSG     = 3'h6,
    MODE_PERSG_ALT = 3'h7
  } mode_e;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RD_SRC  = 4'h1,
    ST_RD_DST  = 4'h2,
    ST_RD_CTL  = 4'h3,
    ST_RD_DATA = 4'h4,
    ST_WR_DATA = 4'h5,
    ST_WB_SRC  = 4'h6,
    ST_WB_DST  = 4'h7,
    ST_WB_CTL  = 4'h8
  } state_e;
endpackage

// *** shared/dma_arb_if.sv ***
// channel request vector and grant between engine and arbiter
`timescale 1ns/10ps
interface dma_arb_if;
  logic [31:0] req;
  logic [31:0] high;
  logic [4:0]  grant;
  logic        found;
  modport requester (output req, output high, input grant, input found);
  modport arbiter (input req, input high, output grant, output found);
endinterface

// *** rtl/dma_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module dma_sync #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// *** rtl/dma_arbiter.sv ***
// two-level fixed-order channel arbiter
`timescale 1ns/10ps
module dma_arbiter import dma_pkg::*; (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // requests and grant
  dma_arb_if.arbiter arb
);
  logic [31:0] hiReq;

  assign hiReq = arb.req & arb.high;

  always_comb begin
    arb.grant = '0;
    arb.found = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.grant = CHW'(i);
        arb.found = 1'b1;
      end
    end
    if (|hiReq) begin
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (hiReq[i]) begin
          arb.grant = CHW'(i);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_high_first;
    |hiReq |-> arb.found && arb.high[arb.grant] && arb.req[arb.grant];
  endproperty
  a_high_first: assert property (p_high_first)
    else $error("low priority channel granted over high");
endmodule

// *** rtl/micro_dma_engine.sv ***
// multi-channel memory transfer engine with table-held descriptors
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
// Operation
// - basic mode moves only while request held
// - auto mode finishes once started
// - ping-pong alternates primary and alternate buffers
// - memory scatter-gather runs task list
// - peripheral scatter-gather paced by request
// - item width 8, 16 or 32 bits
// - addresses step byte, half, word or none
// - two priority levels, high preferred
// - per-channel items between re-arbitration
// - processor bus accesses take precedence
// - software request on any channel
// - channel disables itself on completion
// - remaining count reads zero when done
// - finished structure mode reads stopped
// - peripheral completion on peripheral line
// - engine interrupt: software completion, errors
// - completion flags clear when serviced
// - error flag held until cleared
// - completion event on channel finish
// - global enable gates all transfers
// - thirty-two channels with enable, request state
// - alternate structures at index 32 to 63
// - one to 2047 items per descriptor
// - arbitration size power of two
module micro_dma_engine import dma_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // memory bus master
  output logic             memReq,
  output logic             memWe,
  output logic      [31:0] memAddr,
  output logic      [31:0] memWdata,
  output logic      [1:0]  memSize,
  input  wire logic        memAck,
  input  wire logic        memErr,
  input  wire logic [31:0] memRdata,
  input  wire logic        cpuBusy,
  // peripherals
  input  wire logic [31:0] periphReq,
  output logic      [31:0] periphDone,
  output logic             irq
);
  state_e            state_r, state_nxt;
  logic [CHW-1:0]    curCh_r, curCh_nxt;
  logic              globalEn_r, globalEn_nxt;
  logic [21:0]       base_r, base_nxt;
  logic [31:0]       chanEn_r, chanEn_nxt;
  logic [31:0]       prio_r, prio_nxt;
  logic [31:0]       swReq_r, swReq_nxt;
  logic [31:0]       latch_r, latch_nxt;
  logic [31:0]       altSel_r, altSel_nxt;
  logic [31:0]       swDone_r, swDone_nxt;
  logic [31:0]       periphDone_r, periphDone_nxt;
  logic              err_r, err_nxt;
  logic              irq_r, irq_nxt;
  logic [31:0]       srcPtr_r, srcPtr_nxt;
  logic [31:0]       dstPtr_r, dstPtr_nxt;
  logic [31:0]       ctl_r, ctl_nxt;
  logic [31:0]       dataBuf_r, dataBuf_nxt;
  logic [CNTW-1:0]   cnt_r, cnt_nxt;
  logic [CNTW-1:0]   burst_r, burst_nxt;
  logic              memReq_r, memReq_nxt;
  logic              memWe_r, memWe_nxt;
  logic [31:0]       memAddr_r, memAddr_nxt;
  logic [31:0]       memWdata_r, memWdata_nxt;
  logic [1:0]        memSize_r, memSize_nxt;
  logic [31:0]       regRdata_r, regRdata_nxt;
  logic [31:0]       reqSync;
  logic              step;
  logic              fail;
  logic              finishEvt;
  logic [31:0]       accAddr;
  logic [31:0]       accData;
  logic              accWe;
  logic [1:0]        accSize;
  logic [31:0]       ctlWb;
  mode_e             curMode;
  mode_e             newMode;
  logic              paced;
  logic              reqLive;
  logic              altCur;
  logic              sgPrim;

  dma_arb_if arbBus ();

  dma_sync #(.W(NUM_CH)) u_reqSync (
    .clk (clk),
    .rst (rst),
    .d   (periphReq),
    .q   (reqSync)
  );

  dma_arbiter u_arb (
    .clk (clk),
    .rst (rst),
    .arb (arbBus)
  );

  function automatic logic [31:0] stepOf(input logic [1:0] inc);
    case (inc)
      2'h0:    stepOf = 32'h0000_0001;
      2'h1:    stepOf = 32'h0000_0002;
      2'h2:    stepOf = 32'h0000_0004;
      default: stepOf = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [CNTW-1:0] burstOf(input logic [3:0] arb);
    burstOf = 11'h001 << ((arb > ARB_MAX) ? ARB_MAX : arb);
  endfunction

  function automatic logic isPaced(input mode_e m);
    isPaced = (m == MODE_BASIC) || (m == MODE_PINGPONG) ||
              (m == MODE_PERSG) || (m == MODE_PERSG_ALT);
  endfunction

  // requests seen by the arbiter
  assign arbBus.req  = chanEn_r & (reqSync | swReq_r | latch_r);
  assign arbBus.high = prio_r;

  assign curMode = mode_e'(ctl_r[F_MODE +: 3]);
  assign newMode = mode_e'(memRdata[F_MODE +: 3]);
  assign paced   = isPaced(curMode);
  assign reqLive = reqSync[curCh_r] | swReq_r[curCh_r];
  assign altCur  = altSel_r[curCh_r];
  assign sgPrim  = !altCur && ((curMode == MODE_MEMSG) || (curMode == MODE_PERSG));

  // access decode
  always_comb begin
    ctlWb = ctl_r;
    ctlWb[F_CNT +: CNTW] = cnt_r;
    if (cnt_r == RST_CNT) begin
      ctlWb[F_MODE +: 3] = MODE_STOP;
    end
    accAddr = {base_r, altCur, curCh_r, W_SRC};
    accData = RST_WORD;
    accWe   = 1'b0;
    accSize = SIZE_WORD;
    case (state_r)
      ST_RD_DST:  accAddr = {base_r, altCur, curCh_r, W_DST};
      ST_RD_CTL:  accAddr = {base_r, altCur, curCh_r, W_CTL};
      ST_RD_DATA: begin
        accAddr = srcPtr_r;
        accSize = ctl_r[F_SIZE +: 2];
      end
      ST_WR_DATA: begin
        accAddr = dstPtr_r;
        accSize = ctl_r[F_SIZE +: 2];
        accData = dataBuf_r;
        accWe   = 1'b1;
      end
      ST_WB_SRC: begin
        accData = srcPtr_r;
        accWe   = 1'b1;
      end
      ST_WB_DST: begin
        accAddr = {base_r, altCur, curCh_r, W_DST};
        accData = dstPtr_r;
        accWe   = 1'b1;
      end
      ST_WB_CTL: begin
        accAddr = {base_r, altCur, curCh_r, W_CTL};
        accData = ctlWb;
        accWe   = 1'b1;
      end
      default: accAddr = {base_r, altCur, curCh_r, W_SRC};
    endcase
  end

  // next-state of registers and engine
  always_comb begin
    state_nxt      = state_r;
    curCh_nxt      = curCh_r;
    globalEn_nxt   = globalEn_r;
    base_nxt       = base_r;
    chanEn_nxt     = chanEn_r;
    prio_nxt       = prio_r;
    swReq_nxt      = swReq_r;
    latch_nxt      = latch_r;
    altSel_nxt     = altSel_r;
    swDone_nxt     = swDone_r;
    periphDone_nxt = RST_WORD;
    err_nxt        = err_r;
    srcPtr_nxt     = srcPtr_r;
    dstPtr_nxt     = dstPtr_r;
    ctl_nxt        = ctl_r;
    dataBuf_nxt    = dataBuf_r;
    cnt_nxt        = cnt_r;
    burst_nxt      = burst_r;
    memReq_nxt     = memReq_r;
    memWe_nxt      = memWe_r;
    memAddr_nxt    = memAddr_r;
    memWdata_nxt   = memWdata_r;
    memSize_nxt    = memSize_r;
    regRdata_nxt   = RST_WORD;
    step           = 1'b0;
    fail           = 1'b0;
    finishEvt      = 1'b0;
    if (regWr) begin
      case (regAddr)
        OFF_CFG:   globalEn_nxt = regWdata[0];
        OFF_BASE:  base_nxt = regWdata[31:BASE_LSB];
        OFF_ENSET: chanEn_nxt = chanEn_r | regWdata;
        OFF_ENCLR: chanEn_nxt = chanEn_r & ~regWdata;
        OFF_SWREQ: swReq_nxt = swReq_r | regWdata;
        OFF_PRSET: prio_nxt = prio_r | regWdata;
        OFF_PRCLR: prio_nxt = prio_r & ~regWdata;
        OFF_ERR:   err_nxt = err_r & ~regWdata[0];
        default:   err_nxt = err_r;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFF_CFG:              regRdata_nxt = {31'h0000_0000, globalEn_r};
        OFF_BASE:             regRdata_nxt = {base_r, 10'h000};
        OFF_ENSET, OFF_ENCLR: regRdata_nxt = chanEn_r;
        OFF_SWREQ:            regRdata_nxt = swReq_r;
        OFF_PRSET, OFF_PRCLR: regRdata_nxt = prio_r;
        OFF_ERR:              regRdata_nxt = {31'h0000_0000, err_r};
        OFF_STAT:   regRdata_nxt = {22'h00_0000, state_r != ST_IDLE, curCh_r, state_r};
        OFF_SWDONE: begin
          regRdata_nxt = swDone_r;
          swDone_nxt   = RST_WORD;
        end
        OFF_ALT:              regRdata_nxt = altSel_r;
        default:              regRdata_nxt = RST_WORD;
      endcase
    end
    // one access per state; never start while the processor holds the bus
    if (state_r != ST_IDLE) begin
      if (!memReq_r) begin
        if (!cpuBusy) begin
          memReq_nxt   = 1'b1;
          memAddr_nxt  = accAddr;
          memWe_nxt    = accWe;
          memWdata_nxt = accData;
          memSize_nxt  = accSize;
        end
      end else if (memAck) begin
        memReq_nxt = 1'b0;
        fail       = memErr;
        step       = !memErr;
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (globalEn_r && arbBus.found) begin
          curCh_nxt = arbBus.grant;
          state_nxt = ST_RD_SRC;
        end
      end
      ST_RD_SRC: begin
        if (step) begin
          srcPtr_nxt = memRdata;
          state_nxt  = ST_RD_DST;
        end
      end
      ST_RD_DST: begin
        if (step) begin
          dstPtr_nxt = memRdata;
          state_nxt  = ST_RD_CTL;
        end
      end
      ST_RD_CTL: begin
        if (step) begin
          ctl_nxt   = memRdata;
          cnt_nxt   = memRdata[F_CNT +: CNTW];
          burst_nxt = burstOf(memRdata[F_ARB +: 4]);
          if (!altCur && ((newMode == MODE_MEMSG) || (newMode == MODE_PERSG))) begin
            burst_nxt = SG_TASK_WORDS;
          end
          if ((newMode == MODE_STOP) || (memRdata[F_CNT +: CNTW] == RST_CNT)) begin
            chanEn_nxt[curCh_r] = 1'b0;
            latch_nxt[curCh_r]  = 1'b0;
            state_nxt           = ST_IDLE;
          end else begin
            latch_nxt[curCh_r] = !isPaced(newMode);
            state_nxt          = ST_RD_DATA;
          end
        end
      end
      ST_RD_DATA: begin
        if (step) begin
          dataBuf_nxt = memRdata;
          state_nxt   = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        if (step) begin
          srcPtr_nxt = srcPtr_r + stepOf(ctl_r[F_SINC +: 2]);
          dstPtr_nxt = dstPtr_r + stepOf(ctl_r[F_DINC +: 2]);
          cnt_nxt    = cnt_r - 11'h001;
          burst_nxt  = burst_r - 11'h001;
          if ((cnt_r == 11'h001) || (burst_r == 11'h001) || !globalEn_r ||
              (paced && !reqLive)) begin
            state_nxt = ST_WB_SRC;
          end else begin
            state_nxt = ST_RD_DATA;
          end
        end
      end
      ST_WB_SRC: begin
        if (step) begin
          state_nxt = ST_WB_DST;
        end
      end
      ST_WB_DST: begin
        if (step) begin
          state_nxt = ST_WB_CTL;
        end
      end
      ST_WB_CTL: begin
        if (step) begin
          state_nxt = ST_IDLE;
          if (sgPrim) begin
            altSel_nxt[curCh_r] = 1'b1;
          end else if (cnt_r == RST_CNT) begin
            if (curMode == MODE_PINGPONG) begin
              altSel_nxt[curCh_r] = !altCur;
              finishEvt           = 1'b1;
            end else if ((curMode == MODE_MEMSG_ALT) || (curMode == MODE_PERSG_ALT)) begin
              altSel_nxt[curCh_r] = 1'b0;
            end else begin
              chanEn_nxt[curCh_r] = 1'b0;
              latch_nxt[curCh_r]  = 1'b0;
              swReq_nxt[curCh_r]  = 1'b0;
              altSel_nxt[curCh_r] = 1'b0;
              finishEvt           = 1'b1;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (fail) begin
      err_nxt             = 1'b1;
      chanEn_nxt[curCh_r] = 1'b0;
      latch_nxt[curCh_r]  = 1'b0;
      state_nxt           = ST_IDLE;
    end
    // set wins over the clear-on-read above
    if (finishEvt) begin
      if (swReq_r[curCh_r] || (curCh_r == SW_CHANNEL)) begin
        swDone_nxt[curCh_r] = 1'b1;
      end else begin
        periphDone_nxt[curCh_r] = 1'b1;
      end
    end
    irq_nxt = (|swDone_nxt) || err_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      curCh_r      <= '0;
      globalEn_r   <= 1'b0;
      base_r       <= RST_BASE;
      chanEn_r     <= RST_WORD;
      prio_r       <= RST_WORD;
      swReq_r      <= RST_WORD;
      latch_r      <= RST_WORD;
      altSel_r     <= RST_WORD;
      swDone_r     <= RST_WORD;
      periphDone_r <= RST_WORD;
      err_r        <= 1'b0;
      irq_r        <= 1'b0;
      srcPtr_r     <= RST_WORD;
      dstPtr_r     <= RST_WORD;
      ctl_r        <= RST_WORD;
      dataBuf_r    <= RST_WORD;
      cnt_r        <= RST_CNT;
      burst_r      <= RST_CNT;
      memReq_r     <= 1'b0;
      memWe_r      <= 1'b0;
      memAddr_r    <= RST_WORD;
      memWdata_r   <= RST_WORD;
      memSize_r    <= SIZE_WORD;
      regRdata_r   <= RST_WORD;
    end else begin
      state_r      <= state_nxt;
      curCh_r      <= curCh_nxt;
      globalEn_r   <= globalEn_nxt;
      base_r       <= base_nxt;
      chanEn_r     <= chanEn_nxt;
      prio_r       <= prio_nxt;
      swReq_r      <= swReq_nxt;
      latch_r      <= latch_nxt;
      altSel_r     <= altSel_nxt;
      swDone_r     <= swDone_nxt;
      periphDone_r <= periphDone_nxt;
      err_r        <= err_nxt;
      irq_r        <= irq_nxt;
      srcPtr_r     <= srcPtr_nxt;
      dstPtr_r     <= dstPtr_nxt;
      ctl_r        <= ctl_nxt;
      dataBuf_r    <= dataBuf_nxt;
      cnt_r        <= cnt_nxt;
      burst_r      <= burst_nxt;
      memReq_r     <= memReq_nxt;
      memWe_r      <= memWe_nxt;
      memAddr_r    <= memAddr_nxt;
      memWdata_r   <= memWdata_nxt;
      memSize_r    <= memSize_nxt;
      regRdata_r   <= regRdata_nxt;
    end
  end

  assign regRdata   = regRdata_r;
  assign memReq     = memReq_r;
  assign memWe      = memWe_r;
  assign memAddr    = memAddr_r;
  assign memWdata   = memWdata_r;
  assign memSize    = memSize_r;
  assign periphDone = periphDone_r;
  assign irq        = irq_r;

  // checks
  logic itemDone;
  logic wbDone;
  assign itemDone = (state_r == ST_WR_DATA) && step;
  assign wbDone   = (state_r == ST_WB_CTL) && step;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_basic_pause;
    itemDone && paced && !reqLive && (cnt_r > 11'h001) |=> state_r == ST_WB_SRC;
  endproperty
  a_basic_pause: assert property (p_basic_pause)
    else $error("paced transfer did not pause on dropped request");

  property p_auto_runs;
    itemDone && !paced && (cnt_r > 11'h001) && (burst_r > 11'h001) && globalEn_r
      |=> state_r == ST_RD_DATA;
  endproperty
  a_auto_runs: assert property (p_auto_runs)
    else $error("auto transfer stopped early");

  property p_pingpong;
    wbDone && (curMode == MODE_PINGPONG) && (cnt_r == RST_CNT)
      |=> altCur != $past(altCur) && chanEn_r[curCh_r];
  endproperty
  a_pingpong: assert property (p_pingpong)
    else $error("ping-pong did not switch buffer");

  property p_addr_step;
    itemDone && (ctl_r[F_SINC +: 2] == 2'h2) |=> srcPtr_r == $past(srcPtr_r) + 32'h0000_0004;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("source word step wrong");

  property p_yield;
    $rose(memReq_r) |-> $past(cpuBusy) == 1'b0;
  endproperty
  a_yield: assert property (p_yield)
    else $error("bus request raised while processor busy");

  property p_chan_off;
    wbDone && (cnt_r == RST_CNT) && ((curMode == MODE_BASIC) || (curMode == MODE_AUTO))
      |=> !chanEn_r[curCh_r] ##1 !chanEn_r[curCh_r] || state_r != ST_IDLE;
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("channel still enabled after completion");

  property p_stop_wb;
    (state_r == ST_WB_CTL) && memReq_r && (cnt_r == RST_CNT)
      |-> memWdata_r[F_MODE +: 3] == MODE_STOP && memWdata_r[F_CNT +: CNTW] == RST_CNT;
  endproperty
  a_stop_wb: assert property (p_stop_wb)
    else $error("finished structure not written back as stopped with zero count");

  property p_periph_done;
    wbDone && (cnt_r == RST_CNT) && ((curMode == MODE_BASIC) || (curMode == MODE_AUTO)) &&
      !swReq_r[curCh_r] && (curCh_r != SW_CHANNEL)
      |=> periphDone_r[curCh_r] ##1 periphDone_r == RST_WORD;
  endproperty
  a_periph_done: assert property (p_periph_done)
    else $error("peripheral completion pulse missing");

  property p_irq_src;
    irq_r == (err_r || (|swDone_r));
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt not tied to its sources");

  property p_err_hold;
    err_r && !(regWr && (regAddr == OFF_ERR) && regWdata[0]) |=> err_r && irq_r;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error flag dropped without clear");

  property p_gate;
    (state_r == ST_IDLE) && !globalEn_r |=> state_r == ST_IDLE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("transfer started while globally disabled");

  property p_decrement;
    itemDone |=> cnt_r == $past(cnt_r) - 11'h001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("remaining count not decremented");

  c_complete: cover property (wbDone && (cnt_r == RST_CNT) && (curMode == MODE_BASIC));
  c_pingpong: cover property (wbDone && (curMode == MODE_PINGPONG) && (cnt_r == RST_CNT));
  c_sg_alt:   cover property (wbDone && sgPrim);
  c_error:    cover property (fail);
endmodule

// *** test/mem_model.sv ***
// memory and bus slave model facing the channel engine
`timescale 1ns/10ps
module mem_model (
  // clock
  input  wire logic        clk,
  // bus
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  memSize,
  output logic             memAck,
  output logic             memErr,
  output logic      [31:0] memRdata,
  // test control
  input  wire logic        slow,
  input  wire logic [31:0] errAddr
);
  logic [31:0] m [int];
  logic [31:0] mk;
  logic [31:0] old;
  logic        tick;
  logic        go;
  initial {memAck, memErr, memRdata, tick} = '0;
  always @(posedge clk) begin
    tick <= ~tick;
    go = memReq && !memAck && (!slow || tick);
    mk = (memSize == 2'h2) ? 32'hFFFFFFFF
       : (memSize == 2'h1 ? 32'h0000FFFF : 32'h000000FF) << (8 * memAddr[1:0]);
    old = m.exists(memAddr[31:2]) ? m[memAddr[31:2]] : 32'h0;
    memAck <= go;
    memErr <= go && memAddr == errAddr;
    // idle data lines toggle, never hold the last word
    memRdata <= go ? old : ~memRdata;
    if (go && memWe && memAddr != errAddr)
      m[memAddr[31:2]] = (old & ~mk) | (memWdata & mk);
  end
endmodule

// *** test/micro_dma_channel_engine_tb.sv ***
// self-checking bench for the channel engine
`timescale 1ns/10ps
module micro_dma_channel_engine_tb import dma_pkg::*;;
  logic clk, rst, regWr, regRd, memReq, memWe, memAck, memErr, cpuBusy, irq, slow;
  logic [7:0]  regAddr;
  logic [1:0]  memSize;
  logic [31:0] regWdata, regRdata, memAddr, memWdata, memRdata, periphReq, periphDone;
  logic [31:0] errAddr, v;
  int          fails, n_compared;
  micro_dma_engine DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize), .memAck(memAck),
    .memErr(memErr), .memRdata(memRdata), .cpuBusy(cpuBusy), .periphReq(periphReq),
    .periphDone(periphDone), .irq(irq));
  mem_model mem (.clk(clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memSize(memSize), .memAck(memAck), .memErr(memErr),
    .memRdata(memRdata), .slow(slow), .errAddr(errAddr));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge clk) regWr <= 1'b0;
  endtask
  task rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk) regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // one descriptor of word items, table base at 0x400
  task desc(int ch, logic [31:0] s, logic [31:0] d, logic [2:0] md, int n, int arb);
    mem.m[32'h100 + ch * 4] = s;
    mem.m[32'h101 + ch * 4] = d;
    mem.m[32'h102 + ch * 4] = 32'(md) | n << F_CNT | arb << F_ARB | 32'(SIZE_WORD) << F_SIZE
      | 2 << F_SINC | 2 << F_DINC;
  endtask
  task softAuto;
    for (int i = 0; i < 4; i++) mem.m[32'h400 + i] = 32'hA500 + i;
    desc(31, 32'h1000, 32'h2000, MODE_AUTO, 4, 2);
    wr(OFF_ENSET, 32'h80000000);
    wr(OFF_SWREQ, 32'h80000000);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    chk("irq", irq, 1'b1);
    for (int i = 0; i < 4; i++) chk("dst", mem.m[32'h800 + i], 32'hA500 + i);
    chk("srcWb", mem.m[32'h17C], 32'h1010);
    chk("ctlWb", mem.m[32'h17E] & 32'h7FFF, 32'h0);
    rd(OFF_ENSET, v);
    chk("en", v[31], 1'b0);
    rd(OFF_SWDONE, v);
    chk("done", v[31], 1'b1);
    rd(OFF_SWDONE, v);
    chk("doneClr", v[31], 1'b0);
  endtask
  task periphBasic;
    logic seen;
    seen = 0;
    desc(3, 32'h1000, 32'h2400, MODE_BASIC, 3, 2);
    wr(OFF_ENSET, 32'h8);
    repeat (30) @(posedge clk) seen |= memReq;
    chk("noReq", seen, 1'b0);
    wr(OFF_CFG, 32'h0);
    @(posedge clk) {periphReq, slow} <= {32'h8, 1'b1};
    repeat (30) @(posedge clk) seen |= memReq;
    chk("offIdle", seen, 1'b0);
    @(posedge clk) cpuBusy <= 1'b1;
    wr(OFF_CFG, 32'h1);
    repeat (30) @(posedge clk) seen |= memReq;
    chk("busyIdle", seen, 1'b0);
    @(posedge clk) cpuBusy <= 1'b0;
    // stall the bus and drop the request before the first item is written
    for (int i = 0; i < 300 && !(memReq && !memWe && memAddr == 32'h1000); i++) @(posedge clk);
    {cpuBusy, periphReq} <= {1'b1, 32'h0};
    repeat (6) @(posedge clk);
    cpuBusy <= 1'b0;
    repeat (60) @(posedge clk);
    chk("paused", mem.m[32'h10E] >> F_CNT & 32'h7FF, 32'h2);
    @(posedge clk) periphReq <= 32'h8;
    for (int i = 0; i < 600 && periphDone[3] !== 1'b1; i++) @(posedge clk);
    chk("pdone", periphDone[3], 1'b1);
    chk("noIrq", irq, 1'b0);
    chk("pdst", mem.m[32'h902], 32'hA502);
    @(posedge clk) periphReq <= 32'h0;
  endtask
  task pingPong;
    desc(30, 32'h1000, 32'h2800, MODE_PINGPONG, 1, 0);
    desc(62, 32'h1004, 32'h2804, MODE_PINGPONG, 1, 0);
    wr(OFF_ENSET, 32'h40000000);
    wr(OFF_SWREQ, 32'h40000000);
    repeat (200) @(posedge clk);
    chk("ping", mem.m[32'hA00], 32'hA500);
    chk("pong", mem.m[32'hA01], 32'hA501);
    rd(OFF_ALT, v);
    chk("ppAlt", v[30], 1'b0);
    rd(OFF_SWDONE, v);
    chk("ppDone", v[30], 1'b1);
  endtask
  task busErr;
    desc(31, 32'h3000, 32'h2000, MODE_AUTO, 1, 0);
    wr(OFF_ENSET, 32'h80000000);
    wr(OFF_SWREQ, 32'h80000000);
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
    repeat (5) @(posedge clk);
    rd(OFF_ERR, v);
    chk("err", v[0], 1'b1);
    chk("errIrq", irq, 1'b1);
    wr(OFF_ERR, 32'h1);
    rd(OFF_ERR, v);
    chk("errClr", {v[0], irq}, 2'h0);
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    {rst, regWr, regRd, cpuBusy, slow, regAddr, regWdata, periphReq} = '0;
    rst = 1'b1;
    errAddr = 32'h3000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(OFF_BASE, 32'h400);
    wr(OFF_CFG, 32'h1);
    softAuto();
    periphBasic();
    pingPong();
    busErr();
    close_out();
  end
endmodule
